// ===== udp_framer_pkg.sv
package udp_framer_pkg;

  // register word indices
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_SRC_IP = 3'h1;
  localparam logic [2:0] REG_DST_IP = 3'h2;
  localparam logic [2:0] REG_PORTS = 3'h3;
  localparam logic [2:0] REG_MAC_LO = 3'h4;
  localparam logic [2:0] REG_MAC_HI = 3'h5;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_LSB = 8;
  localparam int SIZE_LSB = 16;

  // frame constants
  localparam logic [15:0] BLANK_PAD = 16'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] ETHERTYPE_IPV4 = 16'h0800;
  localparam logic [7:0] IP_VER_IHL = 8'h45;
  localparam logic [7:0] IP_TOS = 8'h00;
  localparam logic [15:0] IP_FLAGS_DF = 16'h4000;
  localparam logic [7:0] IP_TTL = 8'h80;
  localparam logic [7:0] IP_PROTO_UDP = 8'h11;
  localparam logic [15:0] IP_UDP_HDR_BYTES = 16'h001c;
  localparam logic [15:0] UDP_HDR_BYTES = 16'h0008;
  localparam logic [15:0] UDP_CSUM_NONE = 16'h0000;

  // header word indices
  localparam logic [3:0] HW_MAC_HI = 4'h0;
  localparam logic [3:0] HW_MAC_LO = 4'h1;
  localparam logic [3:0] HW_SRC_MAC = 4'h2;
  localparam logic [3:0] HW_ETYPE = 4'h3;
  localparam logic [3:0] HW_IP_LEN = 4'h4;
  localparam logic [3:0] HW_PACKET_SEQUENCE_ID = 4'h5;
  localparam logic [3:0] HW_IP_CSUM = 4'h6;
  localparam logic [3:0] HW_SRC_IP = 4'h7;
  localparam logic [3:0] HW_DST_IP = 4'h8;
  localparam logic [3:0] HW_PORTS = 4'h9;
  localparam logic [3:0] HW_UDP_LEN = 4'ha;

  // status codes
  localparam logic [3:0] CODE_IDLE = 4'h0;
  localparam logic [3:0] CODE_HDR_BASE = 4'h1;
  localparam logic [3:0] CODE_PAYLOAD = 4'hc;
  localparam logic [3:0] CODE_PAD = 4'hd;
  localparam logic [3:0] CODE_DUMP = 4'he;
  localparam logic [3:0] CODE_DONE = 4'hf;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_PAYLOAD, ST_PAD, ST_DUMP, ST_DONE} framer_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic sop;
    logic eop;
  } stream_beat_t;

  typedef struct packed {
    logic [2:0] addr;
    logic write;
    logic read;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] size;
    logic [31:0] srcIp;
    logic [31:0] dstIp;
    logic [31:0] ports;
    logic [31:0] macLo;
    logic [15:0] macHi;
  } frame_cfg_t;

endpackage

// ===== ipv4_header_checksum.sv
`timescale 1ns/1ps
`default_nettype none
module ipv4_header_checksum
  import udp_framer_pkg::*;
(
  // header fields that vary per frame
  input wire logic [15:0] totalLen,
  input wire logic [15:0] ident,
  input wire logic [31:0] srcIp,
  input wire logic [31:0] dstIp,
  // result
  output logic [15:0] checksum
);
  logic [19:0] sum;
  logic [16:0] fold1;
  logic [15:0] fold2;

  // ones' complement sum of the header with the checksum field taken as zero
  always_comb begin
    sum = {4'h0, IP_VER_IHL, IP_TOS} + {4'h0, totalLen} + {4'h0, ident} + {4'h0, IP_FLAGS_DF}
        + {4'h0, IP_TTL, IP_PROTO_UDP} + {4'h0, srcIp[31:16]} + {4'h0, srcIp[15:0]}
        + {4'h0, dstIp[31:16]} + {4'h0, dstIp[15:0]};
    fold1 = {1'b0, sum[15:0]} + {13'h0000, sum[19:16]};
    // a second fold is enough: nine terms never carry twice
    fold2 = fold1[15:0] + {15'h0000, fold1[16]};
    checksum = ~fold2;
  end
endmodule
`default_nettype wire

// ===== udp_ipv4_packet_framer.sv
`timescale 1ns/1ps
`default_nettype none
module udp_ipv4_packet_framer
  import udp_framer_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire udp_framer_pkg::reg_req_t regReq,
  output udp_framer_pkg::stream_beat_t unusedBeat,
  output logic [31:0] regReadData,
  // sensor stream in
  input wire udp_framer_pkg::stream_beat_t inBeat,
  input wire logic inValid,
  output logic inReady,
  // frame stream out
  output udp_framer_pkg::stream_beat_t outBeat,
  output logic outValid,
  input wire logic outReady
);
  import udp_framer_pkg::*;

  typedef struct packed {
    framer_state_t st;
    logic [3:0] idx;
    logic [15:0] cnt;
    logic [15:0] ipId;
    logic [7:0] ctrl;
    frame_cfg_t regs;
    frame_cfg_t snap;
    logic inReady;
    stream_beat_t outBeat;
    logic outValid;
    logic [31:0] readData;
  } framer_regs_t;

  framer_regs_t r_r;
  framer_regs_t r_nxt;
  logic [15:0] hdrChecksum;
  logic [15:0] ipTotalLen;
  logic [15:0] udpLen;
  logic canLoad;
  logic inTake;
  logic lastWord;

  // lengths from the snapshot taken at frame start
  assign ipTotalLen = 16'({r_r.snap.size, 2'b00}) + IP_UDP_HDR_BYTES;
  assign udpLen = 16'({r_r.snap.size, 2'b00}) + UDP_HDR_BYTES;
  assign canLoad = !r_r.outValid || outReady;
  assign inTake = r_r.inReady && inValid;
  assign lastWord = (r_r.cnt + 16'h0001) == r_r.snap.size;

  // checksum is combinational over the snapshot; it settles long before word 6
  ipv4_header_checksum u_csum (
    .totalLen(ipTotalLen),
    .ident(r_r.ipId),
    .srcIp(r_r.snap.srcIp),
    .dstIp(r_r.snap.dstIp),
    .checksum(hdrChecksum)
  );

  // status code seen by software
  function automatic logic [3:0] stateCode(input framer_state_t st, input logic [3:0] idx);
    case (st)
      ST_IDLE: stateCode = CODE_IDLE;
      ST_HDR: stateCode = CODE_HDR_BASE + idx;
      ST_PAYLOAD: stateCode = CODE_PAYLOAD;
      ST_PAD: stateCode = CODE_PAD;
      ST_DUMP: stateCode = CODE_DUMP;
      ST_DONE: stateCode = CODE_DONE;
      default: stateCode = CODE_IDLE;
    endcase
  endfunction

  // header word by index, octet 0 in the top byte
  function automatic logic [31:0] hdrWord(input logic [3:0] idx, input frame_cfg_t c,
                                          input logic [15:0] id, input logic [15:0] csum,
                                          input logic [15:0] tot, input logic [15:0] ulen);
    case (idx)
      HW_MAC_HI: hdrWord = {BLANK_PAD, c.macHi};
      HW_MAC_LO: hdrWord = c.macLo;
      HW_SRC_MAC: hdrWord = ZERO_WORD;
      HW_ETYPE: hdrWord = {16'h0000, ETHERTYPE_IPV4};
      HW_IP_LEN: hdrWord = {IP_VER_IHL, IP_TOS, tot};
      HW_PACKET_SEQUENCE_ID: hdrWord = {id, IP_FLAGS_DF};
      HW_IP_CSUM: hdrWord = {IP_TTL, IP_PROTO_UDP, csum};
      HW_SRC_IP: hdrWord = c.srcIp;
      HW_DST_IP: hdrWord = c.dstIp;
      HW_PORTS: hdrWord = c.ports;
      HW_UDP_LEN: hdrWord = {ulen, UDP_CSUM_NONE};
      default: hdrWord = ZERO_WORD;
    endcase
  endfunction

  // register read decode; spare words read as zero
  function automatic logic [31:0] regRead(input logic [2:0] a, input framer_regs_t s);
    case (a)
      REG_CTRL: regRead = {s.regs.size, 4'h0, stateCode(s.st, s.idx), s.ctrl};
      REG_SRC_IP: regRead = s.regs.srcIp;
      REG_DST_IP: regRead = s.regs.dstIp;
      REG_PORTS: regRead = s.regs.ports;
      REG_MAC_LO: regRead = s.regs.macLo;
      REG_MAC_HI: regRead = {16'h0000, s.regs.macHi};
      default: regRead = ZERO_WORD;
    endcase
  endfunction

  // next-state logic for the whole block
  always_comb begin
    r_nxt = r_r;
    // every field except inReady holds unless a branch below moves it; inReady is recomputed each cycle
    // register writes; the status byte is read only
    if (regReq.write) begin
      case (regReq.addr)
        REG_CTRL: begin
          r_nxt.ctrl = regReq.wdata[7:0];
          r_nxt.regs.size = regReq.wdata[31:SIZE_LSB];
        end
        REG_SRC_IP: r_nxt.regs.srcIp = regReq.wdata;
        REG_DST_IP: r_nxt.regs.dstIp = regReq.wdata;
        REG_PORTS: r_nxt.regs.ports = regReq.wdata;
        REG_MAC_LO: r_nxt.regs.macLo = regReq.wdata;
        REG_MAC_HI: r_nxt.regs.macHi = regReq.wdata[15:0];
        default: r_nxt.ctrl = r_r.ctrl;
      endcase
    end
    // read data answers one cycle after the request and then holds
    if (regReq.read) begin
      r_nxt.readData = regRead(regReq.addr, r_r);
    end
    // the output beat is gone once the sink takes it
    if (outReady) begin
      r_nxt.outValid = 1'b0;
    end
    case (r_r.st)
      ST_IDLE: begin
        // a frame starts only on a packet start while enabled
        if (r_r.ctrl[CTRL_ENABLE_BIT] && inValid && inBeat.sop) begin
          r_nxt.snap = r_r.regs; // config is frozen for the whole frame
          r_nxt.idx = HW_MAC_HI;
          r_nxt.cnt = 16'h0000;
          r_nxt.st = ST_HDR;
        end
      end
      ST_HDR: begin
        // header words go out whenever the slot is free; input stays held off meanwhile
        if (canLoad) begin
          r_nxt.outBeat.data = hdrWord(r_r.idx, r_r.snap, r_r.ipId, hdrChecksum, ipTotalLen, udpLen);
          r_nxt.outBeat.sop = r_r.idx == HW_MAC_HI;
          r_nxt.outBeat.eop = (r_r.idx == HW_UDP_LEN) && (r_r.snap.size == 16'h0000);
          r_nxt.outValid = 1'b1;
          r_nxt.idx = r_r.idx + 4'h1;
          if (r_r.idx == HW_UDP_LEN) begin
            // an empty payload still has to swallow the input packet
            r_nxt.st = (r_r.snap.size == 16'h0000) ? ST_DUMP : ST_PAYLOAD;
          end
        end
      end
      ST_PAYLOAD: begin
        // each word taken is forwarded at once; there is no buffer to fall back on
        if (inTake) begin
          r_nxt.outBeat.data = inBeat.data;
          r_nxt.outBeat.sop = 1'b0;
          r_nxt.outBeat.eop = lastWord;
          r_nxt.outValid = 1'b1;
          r_nxt.cnt = r_r.cnt + 16'h0001;
          if (lastWord) begin
            r_nxt.st = inBeat.eop ? ST_DONE : ST_DUMP;
          end else if (inBeat.eop) begin
            r_nxt.st = ST_PAD;
          end
        end
      end
      ST_PAD: begin
        // input is ignored here: the source has already closed its packet
        if (canLoad) begin
          r_nxt.outBeat.data = ZERO_WORD;
          r_nxt.outBeat.sop = 1'b0;
          r_nxt.outBeat.eop = lastWord;
          r_nxt.outValid = 1'b1;
          r_nxt.cnt = r_r.cnt + 16'h0001;
          if (lastWord) begin
            r_nxt.st = ST_DONE;
          end
        end
      end
      ST_DUMP: begin
        // surplus words are taken and dropped up to the packet end
        if (inTake && inBeat.eop) begin
          r_nxt.st = ST_DONE;
        end
      end
      ST_DONE: begin
        // the id moves only after the frame, so this frame's checksum used the old value
        r_nxt.ipId = r_r.ipId + 16'h0001;
        r_nxt.st = ST_IDLE;
      end
      default: r_nxt.st = ST_IDLE;
    endcase
    // ready is registered, so in payload it only opens while the output slot stays free (in dump it is always open);
    // this costs every second cycle in payload but keeps every output except the tied-off unusedBeat a flop
    r_nxt.inReady = (r_nxt.st == ST_DUMP) || ((r_nxt.st == ST_PAYLOAD) && !r_nxt.outValid);
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register, except unusedBeat, which is tied to zero
  assign inReady = r_r.inReady;
  assign outBeat = r_r.outBeat;
  assign outValid = r_r.outValid;
  assign regReadData = r_r.readData;
  assign unusedBeat = '0;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // independent ones' complement sum over the emitted header; a correct checksum folds to all ones
  function automatic logic [15:0] onesSum(input logic [15:0] tot, input logic [15:0] id, input logic [31:0] src,
                                          input logic [31:0] dst, input logic [15:0] csum);
    logic [19:0] acc;
    acc = {4'h0, IP_VER_IHL, IP_TOS} + {4'h0, tot} + {4'h0, id} + {4'h0, IP_FLAGS_DF}
        + {4'h0, IP_TTL, IP_PROTO_UDP} + {4'h0, src[31:16]} + {4'h0, src[15:0]}
        + {4'h0, dst[31:16]} + {4'h0, dst[15:0]} + {4'h0, csum};
    // two folds cover ten terms, whose carry never exceeds four bits
    acc = {4'h0, acc[15:0]} + {16'h0000, acc[19:16]};
    acc = {4'h0, acc[15:0]} + {16'h0000, acc[19:16]};
    onesSum = acc[15:0];
  endfunction

  a_idle_when_off: assert property ((r_r.st == ST_IDLE) && !r_r.ctrl[CTRL_ENABLE_BIT] |=> r_r.st == ST_IDLE)
    else $error("frame started while disabled");
  a_status_readback: assert property (regReq.read && (regReq.addr == REG_CTRL) |=>
      regReadData[STATUS_LSB +: 4] == stateCode($past(r_r.st), $past(r_r.idx)))
    else $error("status code mismatch");
  a_dump_code: assert property ((r_r.st == ST_DUMP) && regReq.read && (regReq.addr == REG_CTRL) |=>
      regReadData[STATUS_LSB +: 4] == CODE_DUMP)
    else $error("dump code wrong");
  a_hold_in_header: assert property ((r_r.st == ST_HDR) || (r_r.st == ST_IDLE) |-> !inReady)
    else $error("input taken during header");
  a_frame_start_blank: assert property (outValid && outBeat.sop |-> outBeat.data[31:16] == BLANK_PAD)
    else $error("frame does not start blank");
  a_header_consts: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_ETYPE) |=>
      outBeat.data == {16'h0000, ETHERTYPE_IPV4} ##1 1'b1)
    else $error("ethertype word wrong");
  a_ip_len_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_IP_LEN) |=>
      outBeat.data == {IP_VER_IHL, IP_TOS, 16'({r_r.snap.size, 2'b00}) + IP_UDP_HDR_BYTES})
    else $error("ip length word wrong");
  a_udp_len_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_UDP_LEN) |=>
      outBeat.data == {16'({r_r.snap.size, 2'b00}) + UDP_HDR_BYTES, UDP_CSUM_NONE})
    else $error("udp length word wrong");
  a_exact_length: assert property (outValid && outBeat.eop && (r_r.snap.size != 16'h0000) |->
      r_r.cnt == r_r.snap.size)
    else $error("payload length differs from declared");
  a_pad_zeros: assert property ((r_r.st == ST_PAD) && canLoad |=> outValid && (outBeat.data == ZERO_WORD))
    else $error("padding word not zero");
  a_id_counts: assert property ((r_r.st == ST_DONE) |=> (r_r.ipId == $past(r_r.ipId) + 16'h0001) &&
      (r_r.st == ST_IDLE))
    else $error("packet id not incremented");

  // remaining header words against the configuration frozen at frame start
  a_mac_high_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_MAC_HI) |=>
      outBeat.data == {BLANK_PAD, r_r.snap.macHi})
    else $error("first hardware address word wrong");
  a_mac_low_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_MAC_LO) |=>
      outBeat.data == r_r.snap.macLo)
    else $error("second hardware address word wrong");
  a_src_mac_zero: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_SRC_MAC) |=>
      outBeat.data == ZERO_WORD)
    else $error("source hardware address not zero");
  a_packet_sequence_id_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_PACKET_SEQUENCE_ID) |=>
      outBeat.data == {r_r.ipId, IP_FLAGS_DF})
    else $error("identification word wrong");
  a_ttl_proto: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_IP_CSUM) |=>
      outBeat.data[31:16] == {IP_TTL, IP_PROTO_UDP})
    else $error("lifetime or protocol wrong");
  a_hdr_checksum: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_IP_CSUM) |=>
      onesSum(ipTotalLen, r_r.ipId, r_r.snap.srcIp, r_r.snap.dstIp, outBeat.data[15:0]) == 16'hffff)
    else $error("header checksum does not verify");
  a_src_ip_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_SRC_IP) |=>
      outBeat.data == r_r.snap.srcIp)
    else $error("source address word wrong");
  a_dst_ip_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_DST_IP) |=>
      outBeat.data == r_r.snap.dstIp)
    else $error("destination address word wrong");
  a_port_word: assert property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_PORTS) |=>
      outBeat.data == r_r.snap.ports)
    else $error("port word wrong");

  // stream behaviour on both sides
  a_beat_hold: assert property (outValid && !outReady |=>
      outValid && $stable(outBeat))
    else $error("output beat changed while stalled");
  a_sop_first_word: assert property (outValid && outBeat.sop |->
      (r_r.st == ST_HDR) && (r_r.idx == HW_MAC_LO))
    else $error("start mark outside first header word");
  a_ready_states: assert property (inReady |->
      (r_r.st == ST_PAYLOAD) || (r_r.st == ST_DUMP))
    else $error("input ready outside payload or drop");
  a_dump_silent: assert property ((r_r.st == ST_DUMP) && !outValid |=>
      !outValid)
    else $error("surplus input word forwarded");
  a_payload_forward: assert property ((r_r.st == ST_PAYLOAD) && inTake |=>
      outValid && (outBeat.data == $past(inBeat.data)))
    else $error("payload word not forwarded");

  c_padded_frame: cover property ((r_r.st == ST_PAD) ##[1:300] (r_r.st == ST_DONE));
  c_dumped_frame: cover property ((r_r.st == ST_DUMP) ##[1:300] (r_r.st == ST_DONE));
  c_exact_frame: cover property ((r_r.st == ST_PAYLOAD) && inTake && lastWord && inBeat.eop);
  c_ctrl_write: cover property (regReq.write && (regReq.addr == REG_CTRL));
  c_empty_frame: cover property ((r_r.st == ST_HDR) && canLoad && (r_r.idx == HW_UDP_LEN) && (r_r.snap.size == 16'h0000));
endmodule
`default_nettype wire

// ===== mac_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_sink_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // frame stream from the framer
  input wire udp_framer_pkg::stream_beat_t outBeat,
  input wire logic outValid,
  output logic outReady,
  // accept one beat in this many cycles
  input wire logic [3:0] acceptEvery
);
  import udp_framer_pkg::*;
  stream_beat_t got[$];
  logic [3:0] phase;
  // ready follows a slot pattern, not outValid, so the framer must hold beats while stalled
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase <= 4'h0;
      outReady <= 1'b0;
    end else begin
      if (outValid && outReady) got.push_back(outBeat);
      phase <= (phase + 4'h1 >= acceptEvery) ? 4'h0 : phase + 4'h1;
      outReady <= (phase == 4'h0);
    end
  end
endmodule
`default_nettype wire

// ===== udp_ipv4_packet_framer_test.sv
`timescale 1ns/1ps
`default_nettype none
module udp_ipv4_packet_framer_test;
  import udp_framer_pkg::*;
  logic mclk, resetn, inValid, inReady, outValid, outReady;
  reg_req_t regReq;
  stream_beat_t inBeat, outBeat;
  logic [31:0] regReadData;
  logic [3:0] acceptEvery;
  int badCount = 0;
  int totalChecks = 0;
  // written values, and what reads must return (status not writable, spare words read zero)
  logic [31:0] wv[8] = '{32'h0002_ff00, 32'h1007_000a, 32'h0100_a8c0, 32'hc350_1388,
                         32'h3322_1100, 32'hffff_5544, 32'hffff_ffff, 32'h1234_5678};
  logic [31:0] rv[8] = '{32'h0002_0000, 32'h1007_000a, 32'h0100_a8c0, 32'hc350_1388,
                         32'h3322_1100, 32'h0000_5544, 32'h0000_0000, 32'h0000_0000};

  udp_ipv4_packet_framer dut (.mclk(mclk), .resetn(resetn), .regReq(regReq), .unusedBeat(),
    .regReadData(regReadData), .inBeat(inBeat), .inValid(inValid), .inReady(inReady),
    .outBeat(outBeat), .outValid(outValid), .outReady(outReady));
  mac_sink_model sink (.mclk(mclk), .resetn(resetn), .outBeat(outBeat), .outValid(outValid),
    .outReady(outReady), .acceptEvery(acceptEvery));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    totalChecks++;
    if (seen !== want) begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic regWrite(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk);
    regReq <= '{addr: a, write: 1'b1, read: 1'b0, wdata: d};
    @(posedge mclk);
    regReq <= '{addr: a, write: 1'b0, read: 1'b0, wdata: ~d};
  endtask

  // data is loaded at the taking edge, so it is read back half a cycle later
  task automatic regRead(input logic [2:0] a, output logic [31:0] d);
    @(posedge mclk);
    regReq <= '{addr: a, write: 1'b0, read: 1'b1, wdata: 32'h0000_0000};
    @(posedge mclk);
    regReq.read <= 1'b0;
    @(negedge mclk);
    d = regReadData;
  endtask

  // source keeps each beat until the framer takes it; released data is inverted
  task automatic feed(input int n);
    for (int i = 0; i < n; i++) begin
      inValid <= 1'b1;
      inBeat <= '{data: 32'ha5a5_0000 + i, sop: logic'(i == 0), eop: logic'(i == n - 1)};
      do @(posedge mclk); while (inReady !== 1'b1);
    end
    inValid <= 1'b0;
    inBeat.data <= ~inBeat.data;
  endtask

  task automatic testRegs;
    logic [31:0] rd;
    for (int a = 0; a < 8; a++) begin
      regRead(3'(a), rd);
      check("resetValue", rd, 32'h0000_0000);
    end
    for (int a = 0; a < 8; a++) regWrite(3'(a), wv[a]);
    for (int a = 0; a < 8; a++) begin
      regRead(3'(a), rd);
      check("readBack", rd, rv[a]);
    end
    $display("register test done");
  endtask

  task automatic testDisabled;
    logic busy;
    busy = 1'b0;
    regWrite(REG_CTRL, 32'h0003_0000);
    inValid <= 1'b1;
    inBeat <= '{data: 32'h1234_5678, sop: 1'b1, eop: 1'b1};
    // sampled half a cycle after each edge, where the registered outputs have settled
    repeat (30) begin
      @(negedge mclk);
      if (outValid !== 1'b0 || inReady !== 1'b0) busy = 1'b1;
    end
    @(posedge mclk);
    check("noStartWhenOff", 32'(busy), 32'h0000_0000);
    inValid <= 1'b0;
    inBeat.data <= 32'hedcb_a987;
    $display("disabled test done");
  endtask

  // one packet of nIn words against a declared size, sink taking one beat in every cycles
  task automatic runFrame(input logic [15:0] size, input int nIn, input logic [3:0] every,
                          input logic [15:0] id);
    logic [31:0] exp[$];
    logic [31:0] sum;
    logic [31:0] rd;
    logic [15:0] seen;
    sink.got.delete();
    acceptEvery <= every;
    seen = 16'h0000;
    rd = 32'hffff_ffff;
    sum = 32'h0000_0000;
    regWrite(REG_CTRL, {size, 16'h0001});
    exp = '{{16'h0000, rv[5][15:0]}, rv[4], 32'h0000_0000, 32'h0000_0800,
            {16'h4500, 16'(4 * size + 28)}, {id, 16'h4000}, 32'h8011_0000, rv[1], rv[2], rv[3],
            {16'(4 * size + 8), 16'h0000}};
    for (int i = 4; i < 9; i++) sum += exp[i][31:16] + exp[i][15:0];
    sum = sum[15:0] + sum[31:16];
    sum = sum[15:0] + sum[31:16];
    exp[6][15:0] = ~sum[15:0];
    for (int i = 0; i < size; i++) exp.push_back(i < nIn ? 32'ha5a5_0000 + i : 32'h0000_0000);
    fork
      feed(nIn);
      for (int k = 0; k < 400 && !(sink.got.size() == exp.size() && rd[11:8] == 4'h0); k++) begin
        regRead(REG_CTRL, rd);
        seen[rd[11:8]] = 1'b1;
      end
    join
    check("frameLength", 32'(sink.got.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      check("frameWord", sink.got[i].data, exp[i]);
      check("frameMarks", 32'({sink.got[i].sop, sink.got[i].eop}), 32'({i == 0, i == exp.size() - 1}));
    end
    if (size != 16'h0000) check("payloadCode", 32'(seen[12]), 32'h1);
    check("finalIdle", 32'(rd[11:8]), 32'h0);
    if (nIn < size) check("padCode", 32'(seen[13]), 32'h1);
    if (nIn > size) check("dropCode", 32'(seen[14]), 32'h1);
    $display("frame test size %0d input %0d done", size, nIn);
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    regReq = '0;
    inBeat = '0;
    inValid = 1'b0;
    acceptEvery = 4'h1;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    testRegs;
    testDisabled;
    runFrame(16'h0003, 3, 4'h2, 16'h0000);
    runFrame(16'h0004, 2, 4'h3, 16'h0001);
    runFrame(16'h0002, 8, 4'h1, 16'h0002);
    runFrame(16'h0000, 3, 4'h1, 16'h0003);
    giveVerdict;
  end

  // watchdog: whole run needs a few hundred cycles, so a hang is cut off well after that
  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    giveVerdict;
  end
endmodule
`default_nettype wire
